//--- core/tws_pkg.sv
// Constants, register map and carrier types of the three-wire serial channel
package tws_pkg;

    // Register addresses on the processor port
    localparam logic [15:0] MODE_ADDR  = 16'hff68;
    localparam logic [15:0] CTRL_ADDR  = 16'hff69;
    localparam logic [15:0] COUNT_ADDR = 16'hff6c;
    localparam logic [15:0] SHIFT_ADDR = 16'hff6f;

    // Reset values and writable masks
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'he3;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'h86;
    localparam logic [5:0] COUNT_RESET = 6'h00;

    // Field positions of the auto transfer control register
    localparam int CTRL_RE   = 7;
    localparam int CTRL_TRF  = 3;
    localparam int CTRL_STROBE_HANDSHAKE_ENABLE = 2;
    localparam int CTRL_BUSY = 1;

    // Clock source codes and timer clock select field
    localparam logic [1:0] CLK_TIMER2   = 2'h2;
    localparam int         TCL_SEL_LSB  = 4;

    // Frame length and strobe width
    localparam logic [2:0] LAST_BIT      = 3'h7;
    localparam logic [2:0] STROBE_CYCLES = 3'h3;

    // Mode register layout
    typedef struct packed {
        logic       en;
        logic       lsb_first;
        logic       auto_mode;
        logic [2:0] zero;
        logic [1:0] clk_src;
    } tws_mode_t;

    // Processor register request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } tws_cpu_req_t;

endpackage : tws_pkg

//--- core/tws_prescaler.sv
// Prescaled serial clock tick generator
`timescale 1ns/1ps
`default_nettype none
module tws_prescaler (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // Control
    input  wire logic       run_in,
    input  wire logic [3:0] sel_in,
    // Tick
    output logic            tick_out
);
    import tws_pkg::*;

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        next_tick;
    logic [15:0] limit;

    // Period of 2^(sel+1) cycles, one tick per half serial clock
    always_comb begin
        limit     = (16'h0002 << sel_in) - 16'h0001;
        next_cnt  = cnt + 16'h0001;
        next_tick = 1'b0;
        if (!run_in) begin
            next_cnt = 16'h0000;
        end else if (cnt >= limit) begin
            next_cnt  = 16'h0000;
            next_tick = 1'b1;
        end
    end

    // Register the divider
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt      <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            tick_out <= next_tick;
        end
    end

endmodule : tws_prescaler
`default_nettype wire

//--- core/tws_channel.sv
// Three-wire serial channel with plain and automatic transfer modes
`timescale 1ns/1ps
`default_nettype none
module tws_channel (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  nrst_in,
    // Processor register port
    input  wire tws_pkg::tws_cpu_req_t cpu_req_in,
    output logic [7:0]                 cpu_rdata_out,
    // Clock sources
    input  wire logic                  timer2_tick_in,
    input  wire logic [7:0]            timer_clock_select3_in,
    // Serial pins
    input  wire logic                  serial_clock_pin_in,
    output logic                       serial_clock_pin_out,
    output logic                       serial_clock_pin_oe_out,
    output logic                       serial_out_pin_out,
    output logic                       serial_out_pin_oe_out,
    input  wire logic                  serial_in_pin_in,
    output logic                       serial_in_claimed_out,
    // Handshake lines
    output logic                       strobe_line_out,
    input  wire logic                  busy_line_in,
    // Buffer RAM port
    output logic [5:0]                 ram_addr_out,
    output logic                       ram_rd_out,
    input  wire logic [7:0]            ram_rdata_in,
    output logic                       ram_wr_out,
    output logic [7:0]                 ram_wdata_out,
    // Transfer complete: end of a plain frame or of a whole automatic run
    output logic                       transfer_done_irq_flag_out
);
    import tws_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_LOAD, ST_SHIFT, ST_STROBE
    } tws_state_t;

    // Bus path bit reversal for LSB-first order
    function automatic logic [7:0] tws_order(input logic [7:0] d,
                                             input logic       lsb);
        logic [7:0] r;
        r = d;
        if (lsb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
        end
        return r;
    endfunction : tws_order

    tws_mode_t  mode, next_mode;
    tws_state_t state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic [5:0] count, next_count;
    logic [7:0] sr, next_sr;
    logic       so_latch, next_so_latch;
    logic       sck_int, next_sck_int;
    logic [2:0] bitcnt, next_bitcnt;
    logic [5:0] byte_idx, next_byte_idx;
    logic [2:0] stb_cnt, next_stb_cnt;
    logic       trf, next_trf;
    logic [7:0] rdata, next_rdata;
    logic       sck_oe, so_oe, si_claim, strobe, done;
    logic       next_sck_oe, next_so_oe, next_si_claim;
    logic       next_strobe, next_done;
    logic       ram_rd, ram_wr, next_ram_rd, next_ram_wr;
    logic [7:0] ram_wdata, next_ram_wdata;

    // Pin synchronisers; the third clock stage only feeds edge detection
    logic sck_s1, sck_s2, sck_s3, si_s1, si_s2, busy_s1, busy_s2;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            sck_s1  <= 1'b1;
            sck_s2  <= 1'b1;
            sck_s3  <= 1'b1;
            si_s1   <= 1'b0;
            si_s2   <= 1'b0;
            busy_s1 <= 1'b0;
            busy_s2 <= 1'b0;
        end else begin
            sck_s1  <= serial_clock_pin_in;
            sck_s2  <= sck_s1;
            sck_s3  <= sck_s2;
            si_s1   <= serial_in_pin_in;
            si_s2   <= si_s1;
            busy_s1 <= busy_line_in;
            busy_s2 <= busy_s1;
        end
    end

    // Prescaled clock source runs only when selected
    logic div_tick;
    tws_prescaler u_prescaler (
        .clk_in   (clk_in),
        .nrst_in  (nrst_in),
        .run_in   (mode.en && mode.clk_src == CLK_TIMER2 + 2'h1),
        .sel_in   (timer_clock_select3_in[TCL_SEL_LSB +: 4]),
        .tick_out (div_tick)
    );

    // Serial clock edge events per source
    logic internal, tick, fall_ev, rise_ev;
    logic wr_mode, wr_ctrl, wr_count, wr_sr, start;
    logic busy_en, strobe_handshake_enable_en;
    always_comb begin
        internal = mode.clk_src[1];
        tick     = (mode.clk_src == CLK_TIMER2) ? timer2_tick_in : div_tick;
        fall_ev  = internal ? (tick && sck_int) : (sck_s3 && !sck_s2);
        rise_ev  = internal ? (tick && !sck_int) : (!sck_s3 && sck_s2);
        wr_mode  = cpu_req_in.wr && cpu_req_in.addr == MODE_ADDR;
        wr_ctrl  = cpu_req_in.wr && cpu_req_in.addr == CTRL_ADDR;
        wr_count = cpu_req_in.wr && cpu_req_in.addr == COUNT_ADDR;
        wr_sr    = cpu_req_in.wr && cpu_req_in.addr == SHIFT_ADDR;
        // Only an idle channel with its clock line high may start
        start    = wr_sr && mode.en && state == ST_IDLE
                   && (internal || sck_s2);
        // Handshakes are meaningless on an external clock
        busy_en  = ctrl[CTRL_BUSY] && internal;
        strobe_handshake_enable_en  = ctrl[CTRL_STROBE_HANDSHAKE_ENABLE] && internal;
    end

    // Next state of registers, shifter and sequencer
    always_comb begin
        next_mode      = mode;
        next_ctrl      = ctrl;
        next_count     = count;
        next_sr        = sr;
        next_so_latch  = so_latch;
        next_sck_int   = sck_int;
        next_bitcnt    = bitcnt;
        next_byte_idx  = byte_idx;
        next_stb_cnt   = stb_cnt;
        next_trf       = trf;
        next_state     = state;
        next_strobe    = 1'b0;
        next_done      = 1'b0;
        next_ram_rd    = 1'b0;
        next_ram_wr    = 1'b0;
        next_ram_wdata = ram_wdata;
        if (wr_mode) begin
            next_mode = tws_mode_t'(cpu_req_in.wdata & MODE_WMASK);
        end
        if (wr_ctrl) begin
            next_ctrl = cpu_req_in.wdata & CTRL_WMASK;
        end
        if (wr_count) begin
            next_count = cpu_req_in.wdata[5:0];
        end
        // Writes land only while idle; order fixed at write time
        if (wr_sr && state == ST_IDLE) begin
            next_sr = tws_order(cpu_req_in.wdata, mode.lsb_first);
        end
        case (state)
            ST_IDLE: begin
                next_sck_int = 1'b1;
                next_bitcnt  = 3'h0;
                if (start && mode.auto_mode) begin
                    next_byte_idx = 6'h00;
                    next_trf      = 1'b1;
                    next_ram_rd   = 1'b1;
                    next_state    = ST_LOAD;
                end else if (start) begin
                    next_so_latch = 1'b0;
                    next_state    = ST_SHIFT;
                end
            end
            ST_FETCH: begin
                next_ram_rd = 1'b1;
                next_state  = ST_LOAD;
            end
            ST_LOAD: begin
                next_sr       = tws_order(ram_rdata_in, mode.lsb_first);
                next_so_latch = 1'b0;
                // Hold off the next byte while the peripheral is busy
                if (!(busy_en && busy_s2)) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (fall_ev) begin
                    next_sck_int  = 1'b0;
                    next_so_latch = sr[7];
                    next_sr       = {sr[6:0], sr[0]};
                end
                if (rise_ev) begin
                    next_sck_int = 1'b1;
                    next_sr[0]   = si_s2;
                    next_bitcnt  = bitcnt + 3'h1;
                    if (bitcnt == LAST_BIT) begin
                        next_state = mode.auto_mode ? ST_STROBE : ST_IDLE;
                        next_done  = !mode.auto_mode;
                    end
                end
            end
            ST_STROBE: begin
                next_ram_wdata = tws_order(sr, mode.lsb_first);
                next_ram_wr    = ctrl[CTRL_RE] && stb_cnt == 3'h0;
                next_strobe    = strobe_handshake_enable_en && stb_cnt != STROBE_CYCLES;
                next_stb_cnt   = stb_cnt + 3'h1;
                if (stb_cnt == STROBE_CYCLES) begin
                    next_stb_cnt = 3'h0;
                    next_strobe  = 1'b0;
                    if (byte_idx == count) begin
                        next_trf   = 1'b0;
                        next_done  = 1'b1;
                        next_state = ST_IDLE;
                    end else begin
                        next_byte_idx = byte_idx + 6'h01;
                        next_state    = ST_FETCH;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Disabled channel: shifter stopped and counter cleared
        if (!mode.en) begin
            next_state   = ST_IDLE;
            next_bitcnt  = 3'h0;
            next_sck_int = 1'b1;
            next_trf     = 1'b0;
            next_stb_cnt = 3'h0;
            next_strobe  = 1'b0;
        end
    end

    // Pin roles and register read data
    always_comb begin
        next_so_oe    = next_mode.en;
        next_sck_oe   = next_mode.en && next_mode.clk_src[1];
        next_si_claim = next_mode.en
                        && (next_ctrl[CTRL_RE] || !next_mode.auto_mode);
        next_rdata    = rdata;
        if (cpu_req_in.rd) begin
            case (cpu_req_in.addr)
                MODE_ADDR:  next_rdata = mode;
                CTRL_ADDR:  next_rdata = ctrl | ({7'h00, trf} << CTRL_TRF);
                COUNT_ADDR: next_rdata = {2'h0, count};
                SHIFT_ADDR: next_rdata = tws_order(sr, mode.lsb_first);
                default:    next_rdata = 8'h00;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            mode      <= tws_mode_t'(MODE_RESET);
            ctrl      <= CTRL_RESET;
            count     <= COUNT_RESET;
            sr        <= 8'h00;
            so_latch  <= 1'b0;
            sck_int   <= 1'b1;
            bitcnt    <= 3'h0;
            byte_idx  <= 6'h00;
            stb_cnt   <= 3'h0;
            trf       <= 1'b0;
            state     <= ST_IDLE;
            rdata     <= 8'h00;
            sck_oe    <= 1'b0;
            so_oe     <= 1'b0;
            si_claim  <= 1'b0;
            strobe    <= 1'b0;
            done      <= 1'b0;
            ram_rd    <= 1'b0;
            ram_wr    <= 1'b0;
            ram_wdata <= 8'h00;
        end else begin
            mode      <= next_mode;
            ctrl      <= next_ctrl;
            count     <= next_count;
            sr        <= next_sr;
            so_latch  <= next_so_latch;
            sck_int   <= next_sck_int;
            bitcnt    <= next_bitcnt;
            byte_idx  <= next_byte_idx;
            stb_cnt   <= next_stb_cnt;
            trf       <= next_trf;
            state     <= next_state;
            rdata     <= next_rdata;
            sck_oe    <= next_sck_oe;
            so_oe     <= next_so_oe;
            si_claim  <= next_si_claim;
            strobe    <= next_strobe;
            done      <= next_done;
            ram_rd    <= next_ram_rd;
            ram_wr    <= next_ram_wr;
            ram_wdata <= next_ram_wdata;
        end
    end

    // Outputs straight from flip-flops
    assign cpu_rdata_out              = rdata;
    assign serial_clock_pin_out       = sck_int;
    assign serial_clock_pin_oe_out    = sck_oe;
    assign serial_out_pin_out         = so_latch;
    assign serial_out_pin_oe_out      = so_oe;
    assign serial_in_claimed_out      = si_claim;
    assign strobe_line_out            = strobe;
    assign ram_addr_out               = byte_idx;
    assign ram_rd_out                 = ram_rd;
    assign ram_wr_out                 = ram_wr;
    assign ram_wdata_out              = ram_wdata;
    assign transfer_done_irq_flag_out = done;

    // Checks on the guarded behaviour
    a_mode_reset_zero: assert property (@(posedge clk_in)
        !nrst_in |=> mode == tws_mode_t'(MODE_RESET) && mode.zero == 3'h0)
        else $error("mode register not cleared");
    a_stop_mode_idle: assert property (@(posedge clk_in)
        disable iff (!nrst_in) !mode.en |=> state == ST_IDLE && bitcnt == 3'h0)
        else $error("disabled channel still shifting");
    a_late_enable_nostart: assert property (@(posedge clk_in)
        disable iff (!nrst_in)
        wr_sr && !mode.en && state == ST_IDLE |=> state == ST_IDLE)
        else $error("transfer started while disabled");
    a_write_drives_low: assert property (@(posedge clk_in)
        disable iff (!nrst_in) start && !mode.auto_mode
        |=> !serial_out_pin_out && state == ST_SHIFT)
        else $error("output not low after shift write");
    a_fall_shifts_out: assert property (@(posedge clk_in)
        disable iff (!nrst_in) state == ST_SHIFT && fall_ev && mode.en
        |=> so_latch == $past(sr[7]) && sr[7:1] == $past(sr[6:0]))
        else $error("falling edge did not shift");
    a_rise_samples_in: assert property (@(posedge clk_in)
        disable iff (!nrst_in) state == ST_SHIFT && rise_ev && mode.en
        |=> sr[0] == $past(si_s2))
        else $error("rising edge did not sample input");
    a_eighth_bit_done: assert property (@(posedge clk_in)
        disable iff (!nrst_in) state == ST_SHIFT && rise_ev && mode.en
        && bitcnt == LAST_BIT && !mode.auto_mode
        |=> transfer_done_irq_flag_out && state == ST_IDLE ##1 !done)
        else $error("frame end not flagged");
    a_idle_clock_high: assert property (@(posedge clk_in)
        disable iff (!nrst_in) state == ST_IDLE && mode.en && internal
        |-> serial_clock_pin_out)
        else $error("internal clock not idling high");
    a_busy_holds_load: assert property (@(posedge clk_in)
        disable iff (!nrst_in) state == ST_LOAD && busy_en && busy_s2
        && mode.en |=> state == ST_LOAD)
        else $error("byte started while busy");
    a_clock_pin_role: assert property (@(posedge clk_in)
        disable iff (!nrst_in) mode.en ##1 mode.en
        |-> serial_out_pin_oe_out && serial_clock_pin_oe_out == internal)
        else $error("pin direction wrong while enabled");

endmodule : tws_channel
`default_nettype wire

//--- tb/tws_peer.sv
// Behavioural peripheral on the far side of the serial channel
`timescale 1ns/1ps
`default_nettype none
module tws_peer (
    // Clock, reset and pins
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire logic       sck_in,
    input  wire logic       so_in,
    output logic            si_out,
    // Handshake
    input  wire logic       strobe_in,
    input  wire logic       busy_en_in,
    output logic            busy_out,
    output logic            early_out,
    // Frame data
    input  wire logic [7:0] tx_in,
    output logic [7:0]      rx_out,
    output logic [7:0]      frames_out
);
    logic [7:0] sh;
    logic [3:0] nbit;
    logic       held;

    // Quiet line and empty counters before the first frame
    initial begin
        si_out = 1'b1;
        busy_out = 1'b0;
        early_out = 1'b0;
        frames_out = 8'h00;
        rx_out = 8'h00;
        nbit = 4'h0;
        held = 1'b0;
    end

    // Next bit leaves on every fall; a new byte must wait out busy
    always @(negedge sck_in) begin
        if (nrst_in) begin
            if (busy_out && nbit == 4'h0) begin
                early_out = 1'b1;
            end
            held = 1'b0;
            si_out = tx_in[3'h7 - nbit[2:0]];
        end
    end

    // Capture on every rise; once the hold has run out the line drifts
    always @(posedge sck_in) begin
        if (nrst_in) begin
            sh = {sh[6:0], so_in};
            nbit = nbit + 4'h1;
            if (nbit == 4'h8) begin
                nbit = 4'h0;
                rx_out = sh;
                frames_out = frames_out + 8'h01;
                held = 1'b1;
                repeat (10) @(posedge clk_in);
                if (held) begin
                    si_out = ~si_out;
                end
            end
        end
    end

    // Peripheral stays busy for 30 cycles after each strobe while busy_en_in is set
    always @(posedge strobe_in) begin
        if (busy_en_in) begin
            busy_out = 1'b1;
            repeat (30) @(posedge clk_in);
            busy_out = 1'b0;
        end
    end
endmodule : tws_peer
`default_nettype wire

//--- tb/tws_channel_tb.sv
// Self-checking testbench of the three-wire serial channel
`timescale 1ns/1ps
`default_nettype none
module tws_channel_tb;
    import tws_pkg::*;
    // Design side signals
    logic         clk_in;
    logic         nrst_in;
    tws_cpu_req_t req;
    logic [7:0]   rdata;
    logic         t2;
    logic [7:0]   tcl;
    logic         ext_sck;
    wire logic    sck_pin;
    logic         sck_out, sck_oe, so, so_oe, si, claimed;
    logic         strobe, busy, ram_rd, ram_wr, done;
    logic [5:0]   ram_addr;
    logic [7:0]   ram_rdata, ram_wdata;
    // Far side and bookkeeping
    logic [7:0]   peer_tx, rx, frames, nstb, nrd;
    logic         busy_en, early;
    logic [7:0]   mem [0:63];
    logic [7:0]   wlog [0:63];
    logic [2:0]   tdiv;
    int           err_total;
    int           check_count;

    // Clock pin follows ext_sck while the channel does not drive it
    assign sck_pin = sck_oe ? sck_out : ext_sck;
    // Buffer RAM answers at the address presented
    assign ram_rdata = mem[ram_addr];

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Timer 2 ticks every eight cycles; RAM writes are logged
    always @(posedge clk_in) begin
        tdiv <= tdiv + 3'h1;
        t2 <= (tdiv == 3'h7);
        if (ram_wr === 1'b1) begin
            wlog[ram_addr] <= ram_wdata;
        end
        if (ram_rd === 1'b1) begin
            nrd <= nrd + 8'h01;
        end
    end

    always @(posedge strobe) begin
        nstb = nstb + 8'h01;
    end

    tws_channel dut_u (
        .clk_in                     (clk_in),
        .nrst_in                    (nrst_in),
        .cpu_req_in                 (req),
        .cpu_rdata_out              (rdata),
        .timer2_tick_in             (t2),
        .timer_clock_select3_in     (tcl),
        .serial_clock_pin_in        (sck_pin),
        .serial_clock_pin_out       (sck_out),
        .serial_clock_pin_oe_out    (sck_oe),
        .serial_out_pin_out         (so),
        .serial_out_pin_oe_out      (so_oe),
        .serial_in_pin_in           (si),
        .serial_in_claimed_out      (claimed),
        .strobe_line_out            (strobe),
        .busy_line_in               (busy),
        .ram_addr_out               (ram_addr),
        .ram_rd_out                 (ram_rd),
        .ram_rdata_in               (ram_rdata),
        .ram_wr_out                 (ram_wr),
        .ram_wdata_out              (ram_wdata),
        .transfer_done_irq_flag_out (done)
    );

    tws_peer peer_u (
        .clk_in     (clk_in),
        .nrst_in    (nrst_in),
        .sck_in     (sck_pin),
        .so_in      (so),
        .si_out     (si),
        .strobe_in  (strobe),
        .busy_en_in (busy_en),
        .busy_out   (busy),
        .early_out  (early),
        .tx_in      (peer_tx),
        .rx_out     (rx),
        .frames_out (frames)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req <= '0;
    endtask : reg_wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req <= '0;
        #1;
        chk(rdata, e);
    endtask : rd_chk

    // Bounded wait for the end-of-transfer pulse
    task automatic wait_done;
        int n;
        n = 0;
        // The pulse may be launched at the edge the caller returned on
        #1;
        while (done !== 1'b1) begin
            @(posedge clk_in);
            #1;
            n++;
            if (n > 5000) begin
                err_total++;
                print_verdict;
            end
        end
    endtask : wait_done

    // One frame; an external clock has a long low phase for sync latency
    task automatic xfer(input logic [7:0] d, input logic [7:0] tx,
                        input logic [7:0] erx, input logic [7:0] ebus,
                        input logic ext);
        logic [7:0] f0;
        f0 = frames;
        peer_tx = tx;
        reg_wr(SHIFT_ADDR, d);
        if (ext) begin
            repeat (8) begin
                ext_sck <= 1'b0;
                repeat (5) @(posedge clk_in);
                ext_sck <= 1'b1;
                repeat (3) @(posedge clk_in);
            end
        end
        wait_done;
        repeat (50) @(posedge clk_in);
        chk(frames, f0 + 8'h01);
        chk(rx, erx);
        rd_chk(SHIFT_ADDR, ebus);
        chk({7'h0, sck_out}, 8'h01);
    endtask : xfer

    task automatic t_stop;
        logic [7:0] n;
        logic [7:0] f0;
        n = 8'h00;
        rd_chk(MODE_ADDR, 8'h00);
        reg_wr(MODE_ADDR, 8'hff);
        rd_chk(MODE_ADDR, 8'he3);
        reg_wr(MODE_ADDR, 8'h00);
        rd_chk(16'hff00, 8'h00);
        reg_wr(SHIFT_ADDR, 8'h5a);
        rd_chk(SHIFT_ADDR, 8'h5a);
        chk({5'h0, so_oe, sck_oe, claimed}, 8'h00);
        f0 = frames;
        reg_wr(MODE_ADDR, 8'h82);
        repeat (300) begin
            @(posedge clk_in);
            #1;
            n = n + {7'h0, done === 1'b1};
        end
        chk(n, 8'h00);
        chk(frames, f0);
    endtask : t_stop

    task automatic t_plain;
        chk({5'h0, so_oe, sck_oe, claimed}, 8'h07);
        xfer(8'ha5, 8'h3c, 8'ha5, 8'h3c, 1'b0);
        chk({7'h0, so}, 8'h01);
        peer_tx = 8'h00;
        reg_wr(SHIFT_ADDR, 8'h5a);
        // Look before the first falling edge could move the latch
        #1;
        chk({7'h0, so}, 8'h00);
        wait_done;
        chk(rx, 8'h5a);
    endtask : t_plain

    task automatic t_ext;
        reg_wr(CTRL_ADDR, 8'h00);
        reg_wr(MODE_ADDR, 8'h80);
        @(posedge clk_in);
        #1;
        chk({6'h0, sck_oe, claimed}, 8'h01);
        xfer(8'h69, 8'h96, 8'h69, 8'h96, 1'b1);
    endtask : t_ext

    // Two-byte automatic run paced by the peripheral's busy line
    task automatic t_auto;
        logic [7:0] f0;
        f0 = frames;
        peer_tx = 8'h99;
        busy_en = 1'b1;
        reg_wr(COUNT_ADDR, 8'h01);
        // Internal clock first, so handshakes never meet the external one
        reg_wr(MODE_ADDR, 8'ha2);
        reg_wr(CTRL_ADDR, 8'h86);
        reg_wr(SHIFT_ADDR, 8'h00);
        rd_chk(CTRL_ADDR, 8'h8e);
        wait_done;
        repeat (50) @(posedge clk_in);
        chk(frames - f0, 8'h02);
        chk(rx, 8'hc5);
        chk(wlog[0], 8'h99);
        chk(wlog[1], 8'h99);
        chk(nstb, 8'h02);
        chk(nrd, 8'h02);
        chk({7'h0, early}, 8'h00);
        reg_wr(CTRL_ADDR, 8'h06);
        @(posedge clk_in);
        #1;
        chk({7'h0, claimed}, 8'h00);
    endtask : t_auto

    initial begin
        nrst_in = 1'b0;
        req = '0;
        tcl = 8'h00;
        ext_sck = 1'b1;
        peer_tx = 8'h00;
        busy_en = 1'b0;
        tdiv = 3'h0;
        t2 = 1'b0;
        nstb = 8'h00;
        nrd = 8'h00;
        err_total = 0;
        check_count = 0;
        for (int i = 0; i < 64; i++) begin
            mem[i] = 8'h00;
        end
        mem[0] = 8'h3c;
        mem[1] = 8'hc5;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_stop;
        t_plain;
        reg_wr(MODE_ADDR, 8'hc2);
        xfer(8'h01, 8'h0f, 8'h80, 8'hf0, 1'b0);
        reg_wr(MODE_ADDR, 8'h83);
        tcl <= 8'h30;
        xfer(8'hc3, 8'h81, 8'hc3, 8'h81, 1'b0);
        t_ext;
        t_auto;
        print_verdict;
    end
endmodule : tws_channel_tb
`default_nettype wire
